// ---- src/motor_line_defs.svh ----
// Register indices, address width, field positions and reset values of the motor and line-skip block.
`ifndef MOTOR_LINE_DEFS_SVH
`define MOTOR_LINE_DEFS_SVH

// Printed offsets are register indices; the byte address is four times the index.
`define KEEP_IDX        8'h43
`define GROUP_IDX       8'h44
`define DRIVE_IDX       8'h45
`define STATUS_IDX      8'h60
`define ADDR_W          12
`define IDX_LSB         2

`define KEEP_RST        8'h00
`define GROUP_RST       8'h00
`define DRIVE_RST       4'h0
`define DRIVE_W         4

`define KEEP_FULL       9'h100
`define STAT_MISMATCH   0
`define STAT_IDX_LSB    8
`define STAT_IDX_MSB    15

`endif

// ---- src/motor_line_pkg.sv ----
// Types shared by the motor and line-skip configuration block.
`default_nettype none
`include "motor_line_defs.svh"

package motor_line_pkg;

  // Drive configuration word, low bit first: step mode, sensing phases, phase A and B polarity.
  typedef struct packed {
    logic pol_b;
    logic pol_a;
    logic sense_two;
    logic micro;
  } motor_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } apb_st_e;

  // Lines kept per group from the encoded field.
  function automatic logic [8:0] keep_n(input logic [7:0] t);
    keep_n = 9'(`KEEP_FULL - {1'b0, t});
  endfunction : keep_n

  function automatic logic skip_bypass(input logic [7:0] t, input logic [7:0] m);
    skip_bypass = (t == 8'h00) || (m == 8'h00);
  endfunction : skip_bypass

endpackage : motor_line_pkg
`default_nettype wire

// ---- src/line_skip_counter.sv ----
// Line counter within an n-out-of-m group and the keep decision for each scanned line.
`timescale 1ns/1ps
`default_nettype none
`include "motor_line_defs.svh"

module line_skip_counter (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       scan_start,
  input  wire logic       line_done,
  input  wire logic [7:0] keep_t,
  input  wire logic [7:0] group_m,
  output logic            line_keep,
  output logic [7:0]      group_idx
);

  logic       keep_r;
  logic       keep_nxt;
  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic [7:0] cur;
  logic [7:0] inc;

  always_comb begin
    // A line that ends together with a scan start counts as the first line of the new scan.
    cur      = scan_start ? 8'h00 : idx_r;
    inc      = 8'(cur + 8'h01);
    keep_nxt = 1'b0;
    idx_nxt  = cur;
    if (line_done) begin
      // RULE_03 bypass keeps all
      if (motor_line_pkg::skip_bypass(keep_t, group_m)) begin
        keep_nxt = 1'b1;
      end else begin
        // RULE_01 RULE_02 keep first n
        keep_nxt = ({1'b0, cur} < motor_line_pkg::keep_n(keep_t));
      end
      // RULE_08 wrap after m
      idx_nxt = (inc == group_m) ? 8'h00 : inc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_r <= 1'b0;
      idx_r  <= 8'h00;
    end else if (ce) begin
      keep_r <= keep_nxt;
      idx_r  <= idx_nxt;
    end
  end

  assign line_keep = keep_r;
  assign group_idx = idx_r;

endmodule : line_skip_counter
`default_nettype wire

// ---- src/stepper_motor_line_skip_config.sv ----
// Stepper motor drive and line-skip configuration registers with an APB slave.
//
// Notes on behaviour
// RULE_01 - Keep only n of every m lines.
// RULE_02 - Kept count n equals 256 minus t.
// RULE_03 - Zero t or zero m keeps all.
// RULE_04 - Software matches sensing phases to step mode.
// RULE_05 - One sensing phase forbids microstepping.
// RULE_06 - Phase A polarity bit inverts winding outputs.
// RULE_07 - Phase B polarity bit inverts winding outputs.
// RULE_08 - Group counter restarts per scan and m.
`timescale 1ns/1ps
`default_nettype none
`include "motor_line_defs.svh"

module stepper_motor_line_skip_config (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scan_start,
  input  wire logic        line_done,
  input  wire logic [1:0]  energize_a,
  input  wire logic [1:0]  energize_b,
  output logic             line_keep,
  output logic [1:0]       wind_a,
  output logic [1:0]       wind_b,
  output logic             micro_en,
  output logic             kick_stop_only
);

  motor_line_pkg::apb_st_e    st_r;
  motor_line_pkg::apb_st_e    st_nxt;
  motor_line_pkg::motor_cfg_s cfg_r;
  motor_line_pkg::motor_cfg_s cfg_nxt;
  logic [7:0]                 keep_t_r;
  logic [7:0]                 keep_t_nxt;
  logic [7:0]                 group_m_r;
  logic [7:0]                 group_m_nxt;
  logic [31:0]                prdata_r;
  logic [31:0]                prdata_nxt;
  logic                       pready_r;
  logic                       pready_nxt;
  logic                       pslverr_r;
  logic                       pslverr_nxt;
  logic [1:0]                 wind_a_r;
  logic [1:0]                 wind_a_nxt;
  logic [1:0]                 wind_b_r;
  logic [1:0]                 wind_b_nxt;
  logic                       micro_en_r;
  logic                       micro_en_nxt;
  logic                       kick_r;
  logic                       kick_nxt;
  logic [7:0]                 group_idx;
  logic                       mismatch;
  logic [31:0]                rd_val;
  logic                       rd_hit;

  function automatic logic [`ADDR_W-`IDX_LSB-1:0] reg_index(input logic [11:0] a);
    reg_index = a[`ADDR_W-1:`IDX_LSB];
  endfunction : reg_index

  // The upper index bits must be zero too, or unmapped addresses would alias onto the registers.
  function automatic logic is_reg(input logic [11:0] a, input logic [7:0] idx);
    is_reg = (reg_index(a) == {2'b00, idx}) && (a[`IDX_LSB-1:0] == 2'b00);
  endfunction : is_reg

  line_skip_counter u_count (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .scan_start (scan_start),
    .line_done  (line_done),
    .keep_t     (keep_t_r),
    .group_m    (group_m_r),
    .line_keep  (line_keep),
    .group_idx  (group_idx)
  );

  // RULE_04 sensing-phase mismatch flag
  assign mismatch = (cfg_r.micro != cfg_r.sense_two);

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (is_reg(paddr, `KEEP_IDX)) begin
      rd_val[7:0] = keep_t_r;
    end else if (is_reg(paddr, `GROUP_IDX)) begin
      rd_val[7:0] = group_m_r;
    end else if (is_reg(paddr, `DRIVE_IDX)) begin
      rd_val[`DRIVE_W-1:0] = cfg_r;
    end else if (is_reg(paddr, `STATUS_IDX)) begin
      rd_val[`STAT_MISMATCH]               = mismatch;
      rd_val[`STAT_IDX_MSB:`STAT_IDX_LSB]  = group_idx;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Every access holds one wait cycle, so read data and the error come from flops.
  always_comb begin
    st_nxt      = st_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    keep_t_nxt  = keep_t_r;
    group_m_nxt = group_m_r;
    cfg_nxt     = cfg_r;
    case (st_r)
      motor_line_pkg::ST_IDLE: begin
        if (psel && penable) begin
          st_nxt      = motor_line_pkg::ST_ACK;
          pready_nxt  = 1'b1;
          pslverr_nxt = !rd_hit || (pwrite && is_reg(paddr, `STATUS_IDX));
          prdata_nxt  = pwrite ? 32'h0000_0000 : rd_val;
        end
      end
      motor_line_pkg::ST_ACK: begin
        st_nxt = motor_line_pkg::ST_IDLE;
        if (psel && penable && pwrite) begin
          if (is_reg(paddr, `KEEP_IDX)) begin
            keep_t_nxt = pwdata[7:0];
          end
          if (is_reg(paddr, `GROUP_IDX)) begin
            group_m_nxt = pwdata[7:0];
          end
          if (is_reg(paddr, `DRIVE_IDX)) begin
            cfg_nxt = pwdata[`DRIVE_W-1:0];
          end
        end
      end
      default: begin
        st_nxt = motor_line_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    // RULE_06 phase A polarity
    wind_a_nxt   = energize_a ^ {2{cfg_r.pol_a}};
    // RULE_07 phase B polarity
    wind_b_nxt   = energize_b ^ {2{cfg_r.pol_b}};
    // RULE_05 microstep needs two phases
    micro_en_nxt = cfg_r.micro && cfg_r.sense_two;
    kick_nxt     = !cfg_r.sense_two;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= motor_line_pkg::ST_IDLE;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      keep_t_r   <= `KEEP_RST;
      group_m_r  <= `GROUP_RST;
      cfg_r      <= `DRIVE_RST;
      wind_a_r   <= 2'b00;
      wind_b_r   <= 2'b00;
      micro_en_r <= 1'b0;
      kick_r     <= 1'b0;
    end else if (ce) begin
      st_r       <= st_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      prdata_r   <= prdata_nxt;
      keep_t_r   <= keep_t_nxt;
      group_m_r  <= group_m_nxt;
      cfg_r      <= cfg_nxt;
      wind_a_r   <= wind_a_nxt;
      wind_b_r   <= wind_b_nxt;
      micro_en_r <= micro_en_nxt;
      kick_r     <= kick_nxt;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign wind_a         = wind_a_r;
  assign wind_b         = wind_b_r;
  assign micro_en       = micro_en_r;
  assign kick_stop_only = kick_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // RULE_03 bypass check
  AST_BYPASS_ALL: assert property ( // RULE_03
    ce && line_done && motor_line_pkg::skip_bypass(keep_t_r, group_m_r) |=> line_keep)
    else $error("bypassed line was not kept");

  // RULE_01 drop beyond n
  AST_DROP_REST: assert property ( // RULE_01
    ce && line_done && !scan_start && !motor_line_pkg::skip_bypass(keep_t_r, group_m_r)
    && ({1'b0, group_idx} >= motor_line_pkg::keep_n(keep_t_r)) |=> !line_keep)
    else $error("line beyond kept count was kept");

  // RULE_02 keep below n
  AST_KEEP_FIRST: assert property ( // RULE_02
    ce && line_done && !scan_start && ({1'b0, group_idx} < motor_line_pkg::keep_n(keep_t_r)) |=> line_keep)
    else $error("line inside kept count was dropped");

  // RULE_08 wrap after m
  AST_GROUP_WRAP: assert property ( // RULE_08
    ce && line_done && !scan_start && group_m_r != 8'h00 && group_idx == 8'(group_m_r - 8'h01)
    |=> group_idx == 8'h00)
    else $error("group counter did not wrap after m lines");

  // RULE_08 restart on scan
  AST_SCAN_RESTART: assert property ( // RULE_08
    ce && scan_start && !line_done |=> group_idx == 8'h00)
    else $error("group counter did not restart at scan start");

  // RULE_05 one phase no microstep
  AST_ONE_PHASE: assert property ( // RULE_05
    ce && !cfg_r.sense_two |=> !micro_en && kick_stop_only)
    else $error("microstepping enabled with one sensing phase");

  // RULE_06 idle phase A off
  AST_IDLE_A: assert property ( // RULE_06
    ce && energize_a == 2'b00 |=> wind_a == {2{$past(cfg_r.pol_a)}})
    else $error("phase A idle level does not follow polarity");

  // RULE_07 idle phase B off
  AST_IDLE_B: assert property ( // RULE_07
    ce && energize_b == 2'b00 |=> wind_b == {2{$past(cfg_r.pol_b)}})
    else $error("phase B idle level does not follow polarity");

  AST_APB_WAIT: assert property (
    ce && psel && penable && !pready |=> pready ##1 !pready)
    else $error("access was not answered after one wait cycle");

  AST_APB_WRITE: assert property (
    ce && psel && penable && pready && pwrite && is_reg(paddr, `KEEP_IDX) |=> keep_t_r == $past(pwdata[7:0]))
    else $error("keep count write did not land");

  COV_DROP: cover property (ce && line_done ##1 !line_keep);
  COV_WRAP: cover property (ce && line_done && group_idx != 8'h00 ##1 group_idx == 8'h00);
  COV_MICRO: cover property (micro_en);
  COV_ERR: cover property (pready && pslverr);

endmodule : stepper_motor_line_skip_config
`default_nettype wire

// ---- verification/winding_stage.sv ----
// Motor power stage model that reports which windings carry current.
`timescale 1ns/1ps
`default_nettype none
module winding_stage (
  input  wire logic       pol_a,
  input  wire logic       pol_b,
  input  wire logic [1:0] wind_a,
  input  wire logic [1:0] wind_b,
  output logic [1:0]      on_a,
  output logic [1:0]      on_b
);
  assign on_a = pol_a ? ~wind_a : wind_a;
  assign on_b = pol_b ? ~wind_b : wind_b;
endmodule : winding_stage
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the motor and line-skip configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        scan_start, line_done, line_keep, micro_en, kick_stop_only;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  energize_a, energize_b, wind_a, wind_b, on_a, on_b;
  logic        err, pol_a, pol_b;
  int          errors, tests_run;

  stepper_motor_line_skip_config dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_start(scan_start), .line_done(line_done),
    .energize_a(energize_a), .energize_b(energize_b), .line_keep(line_keep), .wind_a(wind_a),
    .wind_b(wind_b), .micro_en(micro_en), .kick_stop_only(kick_stop_only));
  winding_stage stage (.pol_a(pol_a), .pol_b(pol_b), .wind_a(wind_a), .wind_b(wind_b),
    .on_a(on_a), .on_b(on_b));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task tally_and_finish;
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask : check

  // The request stays put until pready is sampled high.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("unexpected %0t no pready", $time);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task line(input logic s, input logic exp);
    @(posedge pclk);
    scan_start <= s;
    line_done  <= 1'b1;
    @(posedge pclk);
    scan_start <= 1'b0;
    line_done  <= 1'b0;
    @(negedge pclk);
    check(line_keep === exp, "line keep");
  endtask : line

  task t_reset;
    apb(1'b0, 12'h10C, 32'h0);
    check(rd === 32'h0 && err === 1'b0, "keep reset");
    apb(1'b0, 12'h110, 32'h0);
    check(rd === 32'h0, "group reset");
    apb(1'b0, 12'h114, 32'h0);
    check(rd === 32'h0 && kick_stop_only === 1'b1, "drive reset");
  endtask : t_reset

  // Pattern bit 5 is unused; the scan start line is always expected kept, then bits 4 to 0 in order.
  task t_skip(input logic [7:0] t, input logic [7:0] m, input logic [5:0] pat);
    apb(1'b1, 12'h10C, {24'h0, t});
    apb(1'b1, 12'h110, {24'h0, m});
    line(1'b1, 1'b1);
    for (int i = 4; i >= 0; i--) line(1'b0, pat[i]);
    line(1'b1, 1'b1);
  endtask : t_skip

  task t_drive(input logic [3:0] cfg, input logic me, input logic ks);
    apb(1'b1, 12'h114, {28'h0, cfg});
    repeat (2) @(posedge pclk);
    check(micro_en === me && kick_stop_only === ks, "drive mode");
    apb(1'b0, 12'h114, 32'h0);
    check(rd === {28'h0, cfg}, "drive readback");
    apb(1'b0, 12'h180, 32'h0);
    check(rd[0] === 1'b0, "matched mode and phases flagged");
  endtask : t_drive

  // A frozen clock enable ignores lines; a scan start alone clears the group index.
  task t_restart;
    line(1'b1, 1'b1);
    apb(1'b0, 12'h180, 32'h0);
    check(rd === 32'h0000_0100, "status after scan start line");
    @(posedge pclk);
    ce        <= 1'b0;
    line_done <= 1'b1;
    repeat (3) @(posedge pclk);
    ce        <= 1'b1;
    line_done <= 1'b0;
    @(negedge pclk);
    check(line_keep === 1'b0, "line taken while frozen");
    apb(1'b0, 12'h180, 32'h0);
    check(rd === 32'h0000_0100, "index moved while frozen");
    @(posedge pclk);
    scan_start <= 1'b1;
    @(posedge pclk);
    scan_start <= 1'b0;
    apb(1'b0, 12'h180, 32'h0);
    check(rd === 32'h0, "index after bare scan start");
  endtask : t_restart

  task t_pol(input logic pa, input logic pb);
    pol_a <= pa;
    pol_b <= pb;
    apb(1'b1, 12'h114, {28'h0, pb, pa, 2'b00});
    repeat (2) @(posedge pclk);
    check(on_a === energize_a && on_b === energize_b, "winding drive");
    check(wind_a === (energize_a ^ {2{pa}}) && wind_b === (energize_b ^ {2{pb}}), "phase levels");
    energize_a <= 2'b00;
    energize_b <= 2'b00;
    repeat (2) @(posedge pclk);
    check(wind_a === {2{pa}} && wind_b === {2{pb}}, "idle winding level");
    check(on_a === 2'b00 && on_b === 2'b00, "idle windings energized");
    energize_a <= 2'b01;
    energize_b <= 2'b10;
  endtask : t_pol

  task t_err;
    apb(1'b0, 12'h200, 32'h0);
    check(err === 1'b1, "unmapped read");
    apb(1'b1, 12'h180, 32'h1);
    check(err === 1'b1, "status write");
    apb(1'b0, 12'h10E, 32'h0);
    check(err === 1'b1, "misaligned read");
    apb(1'b0, 12'h50C, 32'h0);
    check(err === 1'b1, "aliased read");
  endtask : t_err

  initial begin
    {presetn, psel, penable, pwrite, scan_start, line_done, pol_a, pol_b} = '0;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    energize_a = 2'b01;
    energize_b = 2'b10;
    errors = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_skip(8'hFE, 8'h03, 6'b110110);
    t_skip(8'hFF, 8'h03, 6'b100100);
    t_skip(8'h00, 8'h03, 6'b111111);
    t_skip(8'hFE, 8'h00, 6'b111111);
    t_restart();
    t_drive(4'h3, 1'b1, 1'b0);
    t_drive(4'h0, 1'b0, 1'b1);
    t_pol(1'b1, 1'b0);
    t_pol(1'b0, 1'b1);
    t_pol(1'b0, 1'b0);
    t_err();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
